// [hw/dcr_consts.svh]
// Offsets, field positions and reset values of the DMA channel block.
// Assumes a 32-bit APB with one aligned word per register.
`ifndef DCR_CONSTS_SVH
`define DCR_CONSTS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define DCR_OFS_SRC_LO   8'h00
`define DCR_OFS_SRC_HI   8'h04
`define DCR_OFS_DST_LO   8'h08
`define DCR_OFS_DST_HI   8'h0c
`define DCR_OFS_COUNT    8'h10
`define DCR_OFS_ADC      8'h14
`define DCR_OFS_CHC      8'h18
`define DCR_OFS_TRIG     8'h1c
`define DCR_OFS_STAT     8'h20
`define DCR_OFS_MASK     8'h24

// ----------------------------------------
// Field positions
// ----------------------------------------
`define DCR_ADC_SIZE     14
`define DCR_ADC_SMODE_HI 7
`define DCR_ADC_SMODE_LO 6
`define DCR_ADC_DMODE_HI 5
`define DCR_ADC_DMODE_LO 4
`define DCR_CHC_EN       0
`define DCR_CHC_INIT     1
`define DCR_CHC_STRIG    2
`define DCR_CHC_TC       7
`define DCR_TRIG_FLAG    8
`define DCR_STAT_TC      0
`define DCR_STAT_REQ     1

// ----------------------------------------
// Widths and reset values
// ----------------------------------------
`define DCR_ADDR_W       26
`define DCR_HI_USED      10
`define DCR_NUM_IRQ      64
`define DCR_RST_16       16'h0000
`define DCR_RST_8        8'h00

`endif

// [hw/dcr_pkg.sv]
// Types shared by the DMA channel block and its surroundings.
// Assumes the constants header is included alongside.
package dcr_pkg;

	// Address step modes of the address/size control register
	typedef enum logic [1:0] {
		DCR_STEP_INC   = 2'b00,
		DCR_STEP_DEC   = 2'b01,
		DCR_STEP_FIXED = 2'b10,
		DCR_STEP_RSVD  = 2'b11
	} dcr_step_t;

	// One request to the internal bus
	typedef struct packed {
		logic [25:0] addr;
		logic        write;
		logic        size16;
		logic [15:0] wdata;
	} dcr_bus_req_t;

	// APB request side
	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} dcr_apb_req_t;

endpackage

// [hw/dcr_channel.sv]
// One DMA channel: APB register file, trigger logic and transfer engine.
// Assumes a single 10 MHz clock, synchronous inputs and a bus that
// acknowledges each read or write with a one-cycle busAck.
//
// Behaviour
// - Address halves read separately, may be intermediate
// - Size bit picks 8 or 16 bit units
// - 16-bit transfers start at even address
// - Terminal-count flag is read-only
// - Initialize and trigger bits are write-only actions
// - Enable clears first, terminal count sets after
// - Read during completion may show both zero
// - Selected interrupt sets request flag, starts if enabled
// - Standby interrupts set nothing, start nothing
//
// Chosen here: register access over APB and the register addresses.
`timescale 1ns/10ps
`include "dcr_consts.svh"

module dcr_channel #(
	parameter int ADDR_W = `DCR_ADDR_W,	// Transfer address width
	parameter int NUM_IRQ = `DCR_NUM_IRQ	// Trigger sources
) (
	input  wire logic                 clk,        // 10 MHz clock
	input  wire logic                 rst,        // Sync reset, high
	input  wire dcr_pkg::dcr_apb_req_t apbReq,    // APB request
	output logic                      pready,     // APB ready
	output logic                      pslverr,    // Unmapped address
	output logic [31:0]               prdata,     // APB read data
	input  wire logic [NUM_IRQ-1:0]   periphIrq,  // Peripheral pulses
	input  wire logic                 standby,    // Device in standby
	output logic                      busReqValid,// Bus request
	output dcr_pkg::dcr_bus_req_t     busReq,     // Bus request data
	input  wire logic                 busAck,     // Bus done, pulse
	input  wire logic [15:0]          busRdData,  // Bus read data
	output logic                      irq         // Level interrupt
);

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	typedef enum logic [1:0] {S_IDLE, S_READ, S_WRITE} dcr_state_t;

	dcr_state_t    state_reg;
	logic [15:0]   srcLo_reg;
	logic [15:0]   srcHi_reg;
	logic [15:0]   dstLo_reg;
	logic [15:0]   dstHi_reg;
	logic [15:0]   count_reg;
	logic [15:0]   adc_reg;
	logic          enable_reg;
	logic          tc_reg;
	logic          tcPend_reg;
	logic [5:0]    trigSel_reg;
	logic          reqFlag_reg;
	logic [1:0]    stat_reg;
	logic [1:0]    mask_reg;
	logic [15:0]   data_reg;
	logic          firstUnit_reg;
	logic [31:0]   prdata_reg;
	logic          wrEn;
	logic          rdSetup;
	logic          mapped;
	logic          size16;
	logic          trigHit;
	logic          swTrig;
	logic          initHit;
	logic          startUnit;
	logic          unitDone;
	logic          lastUnit;
	logic [ADDR_W-1:0] srcAddr;
	logic [ADDR_W-1:0] dstAddr;
	logic [ADDR_W-1:0] srcNext;
	logic [ADDR_W-1:0] dstNext;

	// Step an address by the unit size in the chosen mode
	function automatic logic [ADDR_W-1:0] stepAddr(
		input logic [ADDR_W-1:0] a,
		input logic [1:0]        mode,
		input logic              wide
	);
		logic [ADDR_W-1:0] d;
		d = wide ? ADDR_W'(2) : ADDR_W'(1);
		case (dcr_pkg::dcr_step_t'(mode))
			dcr_pkg::DCR_STEP_INC: stepAddr = a + d;
			dcr_pkg::DCR_STEP_DEC: stepAddr = a - d;
			default:               stepAddr = a;
		endcase
	endfunction

	// Decode of a write to one register offset
	function automatic logic hitReg(input logic [7:0] ofs);
		hitReg = wrEn && (apbReq.paddr == ofs);
	endfunction

	// ----------------------------------------
	// APB slave
	// ----------------------------------------
	// No wait states: every register answers in its access cycle
	// Zero-wait slave; read data captured in the setup cycle
	assign pready  = 1'b1;
	assign wrEn    = apbReq.psel & apbReq.penable & apbReq.pwrite;
	assign rdSetup = apbReq.psel & ~apbReq.penable & ~apbReq.pwrite;
	assign prdata  = prdata_reg;

	always_comb begin
		case (apbReq.paddr)
			`DCR_OFS_SRC_LO, `DCR_OFS_SRC_HI, `DCR_OFS_DST_LO,
			`DCR_OFS_DST_HI, `DCR_OFS_COUNT, `DCR_OFS_ADC,
			`DCR_OFS_CHC, `DCR_OFS_TRIG, `DCR_OFS_STAT,
			`DCR_OFS_MASK: mapped = 1'b1;
			default:       mapped = 1'b0;
		endcase
	end
	assign pslverr = apbReq.psel & apbReq.penable & ~mapped;

	// Read mux; halves read apart, so a live address may tear
	always_ff @(posedge clk) begin
		if (rst) begin
			prdata_reg <= 32'h00000000;
		end else if (rdSetup) begin
			case (apbReq.paddr)
				`DCR_OFS_SRC_LO: prdata_reg <= {16'h0000, srcLo_reg};
				`DCR_OFS_SRC_HI: prdata_reg <= {16'h0000, srcHi_reg};
				`DCR_OFS_DST_LO: prdata_reg <= {16'h0000, dstLo_reg};
				`DCR_OFS_DST_HI: prdata_reg <= {16'h0000, dstHi_reg};
				`DCR_OFS_COUNT:  prdata_reg <= {16'h0000, count_reg};
				`DCR_OFS_ADC:    prdata_reg <= {16'h0000, adc_reg};
				// Action bits read as zero
				`DCR_OFS_CHC:    prdata_reg <= {24'h000000, tc_reg,
					6'h00, enable_reg};
				`DCR_OFS_TRIG:   prdata_reg <= {23'h000000, reqFlag_reg,
					2'h0, trigSel_reg};
				`DCR_OFS_STAT:   prdata_reg <= {30'h00000000, stat_reg};
				`DCR_OFS_MASK:   prdata_reg <= {30'h00000000, mask_reg};
				default:         prdata_reg <= 32'h00000000;
			endcase
		end
	end

	// ----------------------------------------
	// Configuration registers
	// ----------------------------------------
	// Stored as written; reserved ADC bits are kept, software zeroes them
	always_ff @(posedge clk) begin
		if (rst) begin
			adc_reg     <= `DCR_RST_16;
			trigSel_reg <= 6'h00;
			mask_reg    <= 2'h0;
		end else begin
			if (hitReg(`DCR_OFS_ADC))
				adc_reg <= apbReq.pwdata[15:0];
			if (hitReg(`DCR_OFS_TRIG))
				trigSel_reg <= apbReq.pwdata[5:0];
			if (hitReg(`DCR_OFS_MASK))
				mask_reg <= apbReq.pwdata[1:0];
		end
	end

	// Step mode 11 acts as fixed; software should not rely on it
	assign size16 = adc_reg[`DCR_ADC_SIZE];

	// ----------------------------------------
	// Address and count registers
	// ----------------------------------------
	assign srcAddr = {srcHi_reg[`DCR_HI_USED-1:0], srcLo_reg};
	assign dstAddr = {dstHi_reg[`DCR_HI_USED-1:0], dstLo_reg};
	// Next addresses step from the aligned start, so an odd start in
	// 16-bit mode never carries its low bit into later units
	assign srcNext = stepAddr(srcAddr & {{(ADDR_W-1){1'b1}},
		~(size16 & firstUnit_reg)},
		adc_reg[`DCR_ADC_SMODE_HI:`DCR_ADC_SMODE_LO], size16);
	assign dstNext = stepAddr(dstAddr & {{(ADDR_W-1){1'b1}},
		~(size16 & firstUnit_reg)},
		adc_reg[`DCR_ADC_DMODE_HI:`DCR_ADC_DMODE_LO], size16);
	// Count 0 or 1 both end the block; 0 never wraps to a long run
	assign lastUnit = (count_reg <= 16'h0001);

	// Engine steps per unit; software writes land in any cycle but a unit's last
	always_ff @(posedge clk) begin
		if (rst) begin
			srcLo_reg <= `DCR_RST_16;
			srcHi_reg <= `DCR_RST_16;
			dstLo_reg <= `DCR_RST_16;
			dstHi_reg <= `DCR_RST_16;
			count_reg <= `DCR_RST_16;
		end else if (unitDone) begin
			srcLo_reg <= srcNext[15:0];
			srcHi_reg[`DCR_HI_USED-1:0] <= srcNext[ADDR_W-1:16];
			dstLo_reg <= dstNext[15:0];
			dstHi_reg[`DCR_HI_USED-1:0] <= dstNext[ADDR_W-1:16];
			count_reg <= count_reg - 16'h0001;
		end else begin
			if (hitReg(`DCR_OFS_SRC_LO))
				srcLo_reg <= apbReq.pwdata[15:0];
			if (hitReg(`DCR_OFS_SRC_HI))
				srcHi_reg <= apbReq.pwdata[15:0];
			if (hitReg(`DCR_OFS_DST_LO))
				dstLo_reg <= apbReq.pwdata[15:0];
			if (hitReg(`DCR_OFS_DST_HI))
				dstHi_reg <= apbReq.pwdata[15:0];
			if (hitReg(`DCR_OFS_COUNT))
				count_reg <= apbReq.pwdata[15:0];
		end
	end

	// ----------------------------------------
	// Channel control
	// ----------------------------------------
	assign initHit = hitReg(`DCR_OFS_CHC) &
		apbReq.pwdata[`DCR_CHC_INIT];
	assign swTrig  = hitReg(`DCR_OFS_CHC) &
		apbReq.pwdata[`DCR_CHC_STRIG];

	// Enable drops at the end, the flag rises one cycle later
	always_ff @(posedge clk) begin
		if (rst) begin
			enable_reg <= 1'b0;
			tc_reg     <= 1'b0;
			tcPend_reg <= 1'b0;
		end else if (initHit) begin
			enable_reg <= 1'b0;
			tc_reg     <= 1'b0;
			tcPend_reg <= 1'b0;
		end else begin
			tcPend_reg <= unitDone & lastUnit;
			// One cycle shows enable 0 and flag 0 here
			if (tcPend_reg)
				tc_reg <= 1'b1;
			else if (hitReg(`DCR_OFS_CHC) &
				apbReq.pwdata[`DCR_CHC_EN])
				tc_reg <= 1'b0;	// Re-enable starts a new block
			if (unitDone & lastUnit)
				enable_reg <= 1'b0;
			else if (hitReg(`DCR_OFS_CHC))
				enable_reg <= apbReq.pwdata[`DCR_CHC_EN];
			// The written TC bit never reaches the flag itself
		end
	end

	// ----------------------------------------
	// Request flag
	// ----------------------------------------
	// Set wins over start and software clears, not init; standby blocks only the peripheral set
	assign trigHit = ~standby & periphIrq[trigSel_reg];

	always_ff @(posedge clk) begin
		if (rst) begin
			reqFlag_reg <= 1'b0;
		end else if (initHit) begin
			reqFlag_reg <= 1'b0;
		end else if (trigHit | swTrig) begin
			reqFlag_reg <= 1'b1;	// Regardless of enable
		end else if (startUnit) begin
			reqFlag_reg <= 1'b0;
		end else if (hitReg(`DCR_OFS_TRIG) &
			~apbReq.pwdata[`DCR_TRIG_FLAG]) begin
			reqFlag_reg <= 1'b0;	// Software may only clear
		end
	end

	// ----------------------------------------
	// Transfer engine
	// ----------------------------------------
	// Starts at once when enabled with a pending request
	assign startUnit = (state_reg == S_IDLE) & enable_reg & reqFlag_reg;
	assign unitDone  = (state_reg == S_WRITE) & busAck;

	// Init drops a phase in flight; the bus side must tolerate that
	always_ff @(posedge clk) begin
		if (rst | initHit) begin
			state_reg <= S_IDLE;
		end else begin
			case (state_reg)
				S_IDLE:  if (startUnit) state_reg <= S_READ;
				S_READ:  if (busAck) state_reg <= S_WRITE;
				S_WRITE: if (busAck) state_reg <= S_IDLE;
				default: state_reg <= S_IDLE;
			endcase
		end
	end

	// First unit after reset, a finished block or init (unless a unit ends that cycle) is the aligned start
	always_ff @(posedge clk) begin
		if (rst) begin
			firstUnit_reg <= 1'b1;
		end else if (unitDone) begin
			firstUnit_reg <= lastUnit;
		end else if (initHit) begin
			firstUnit_reg <= 1'b1;
		end
	end

	// Latch read data between the two bus phases
	always_ff @(posedge clk) begin
		if (rst) begin
			data_reg <= 16'h0000;
		end else if (state_reg == S_READ && busAck) begin
			data_reg <= size16 ? busRdData : {8'h00, busRdData[7:0]};
		end
	end

	// Only the first unit is forced; later ones follow the step
	// Bus request; odd start forced even in 16-bit mode
	always_comb begin
		busReqValid   = (state_reg == S_READ) | (state_reg == S_WRITE);
		busReq.write  = (state_reg == S_WRITE);
		busReq.size16 = size16;
		busReq.wdata  = data_reg;
		busReq.addr   = (state_reg == S_WRITE) ? dstAddr : srcAddr;
		if (size16 & firstUnit_reg)
			busReq.addr[0] = 1'b0;
	end

	// ----------------------------------------
	// Interrupts
	// ----------------------------------------
	// Request event counts software triggers too, even in standby
	// Sticky events, write one to clear; a new event wins
	always_ff @(posedge clk) begin
		if (rst) begin
			stat_reg <= 2'h0;
		end else begin
			for (int i = 0; i < 2; i++) begin
				if ((i == `DCR_STAT_TC) ? tcPend_reg :
					(trigHit | swTrig))
					stat_reg[i] <= 1'b1;
				else if (hitReg(`DCR_OFS_STAT) & apbReq.pwdata[i])
					stat_reg[i] <= 1'b0;
			end
		end
	end

	assign irq = |(stat_reg & mask_reg);

endmodule

// [sim/dcr_channel_assertions.sv]
// Checker for the DMA channel ports: APB answer and bus engine order.
// Assumes it is bound to dcr_channel and sees only its ports.
`timescale 1ns/10ps
module dcr_channel_assertions (
	input wire logic                  clk,         // Clock
	input wire logic                  rst,         // Sync reset
	input wire dcr_pkg::dcr_apb_req_t apbReq,      // APB request
	input wire logic                  pslverr,     // APB error
	input wire logic [31:0]           prdata,      // APB read data
	input wire logic                  busReqValid, // Bus request
	input wire dcr_pkg::dcr_bus_req_t busReq,      // Bus request data
	input wire logic                  busAck,      // Bus phase done
	input wire logic [15:0]           busRdData,   // Bus read data
	input wire logic                  irq          // Interrupt
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// ------
	// Engine
	// ------
	chk_read_first: assert property (
		$rose(busReqValid) |-> !busReq.write) else $error("write first");
	chk_req_held: assert property (
		busReqValid && !busAck |=> busReqValid && $stable(busReq))
		else $error("request moved");
	chk_write_next: assert property (
		busReqValid && busAck && !busReq.write |=> busReqValid
		&& busReq.write && busReq.size16 == $past(busReq.size16))
		else $error("no write phase");
	chk_unit_ends: assert property (
		busReqValid && busAck && busReq.write |=> !busReqValid)
		else $error("unit not ended");
	// Byte units carry only the low lane, upper byte zero
	chk_wdata_copy: assert property (
		busReqValid && busAck && !busReq.write |=> busReq.wdata ==
		($past(busRdData) & (busReq.size16 ? 16'hffff : 16'h00ff)))
		else $error("write data");
	// ------
	// Registers
	// ------
	chk_err_phase: assert property (
		pslverr |-> apbReq.psel && apbReq.penable)
		else $error("error outside access");
	chk_rdata_hold: assert property (
		!(apbReq.psel && !apbReq.penable && !apbReq.pwrite)
		|=> $stable(prdata)) else $error("read data moved");
	// Sticky status: only a write may drop the interrupt
	chk_irq_hold: assert property (
		irq && !(apbReq.psel && apbReq.penable && apbReq.pwrite)
		|=> irq) else $error("irq dropped");
endmodule

// [sim/dcr_bus_model.sv]
// Internal bus answering each channel phase, read data made from the address.
// Assumes one busAck pulse per phase; read data depends on address.
`timescale 1ns/10ps
module dcr_bus_model (
	input wire logic                  clk,         // Clock
	input wire logic                  rst,         // Sync reset
	input wire logic                  busReqValid, // Channel request
	input wire dcr_pkg::dcr_bus_req_t busReq,      // Request data
	output logic                      busAck,      // Phase done
	output logic [15:0]               busRdData    // Read data
);
	int waitCnt = 0;
	initial begin
		busAck = 1'b0;
		busRdData = 16'h0000;
	end
	// Random latency; data toggles outside the answer so none is trusted
	always @(posedge clk) begin
		busAck <= 1'b0;
		busRdData <= ~busRdData;
		if (rst)
			waitCnt <= 0;
		else if (busReqValid && !busAck) begin
			if (waitCnt == 0) begin
				busAck <= 1'b1;
				busRdData <= busReq.addr[15:0] ^ 16'ha5c3;
				waitCnt <= int'($urandom_range(3));
			end else
				waitCnt <= waitCnt - 1;
		end
	end
endmodule

// [sim/dcr_channel_tb_top.sv]
// Bench for one DMA channel: APB master, bus model, queued checks.
// Assumes the constants header is on the include path.
`timescale 1ns/10ps
`include "dcr_consts.svh"
module dcr_channel_tb_top;
	logic                  clk = 1'b0;
	logic                  rst = 1'b1;
	dcr_pkg::dcr_apb_req_t apbReq = '0;
	logic [63:0]           periphIrq = '0;
	logic                  standby = 1'b0;
	logic                  pready, pslverr, busReqValid, busAck, irq;
	logic [31:0]           prdata;
	logic [15:0]           busRdData;
	dcr_pkg::dcr_bus_req_t busReq;
	logic [32:0]           rdQ[$];
	logic [43:0]           busQ[$];
	logic [25:0]           src, dst;
	int                    bad_count = 0;
	int                    tests_run = 0;

	initial forever #50 clk = ~clk;
	dcr_channel u_dcr_channel (.clk(clk), .rst(rst), .apbReq(apbReq),
		.pready(pready), .pslverr(pslverr), .prdata(prdata),
		.periphIrq(periphIrq), .standby(standby),
		.busReqValid(busReqValid), .busReq(busReq), .busAck(busAck),
		.busRdData(busRdData), .irq(irq));
	dcr_bus_model u_dcr_bus_model (.clk(clk), .rst(rst),
		.busReqValid(busReqValid), .busReq(busReq), .busAck(busAck),
		.busRdData(busRdData));

	task automatic end_of_test;
		if (bad_count == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic fail(input string m);
		bad_count++;
		$display("mismatch at %0t: %s", $time, m);
	endtask
	// ------
	// Drivers
	// ------
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int i;
		@(posedge clk);
		apbReq <= '{1'b1, 1'b0, w, a, d};
		@(posedge clk);
		apbReq.penable <= 1'b1;
		for (i = 0; i < 16; i++) begin
			@(posedge clk);
			if (pready === 1'b1)
				break;
		end
		apbReq.psel <= 1'b0;
		apbReq.penable <= 1'b0;
		if (i == 16) begin
			fail("apb hang");
			end_of_test;
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e,
		input logic err = 1'b0);
		rdQ.push_back({err, e});
		apb(1'b0, a, 32'h0);
	endtask
	// Expected read then write of one unit, data as the model returns it
	task automatic unit(input logic [25:0] s, input logic [25:0] d,
		input logic w16);
		logic [15:0] r;
		r = s[15:0] ^ 16'ha5c3;
		busQ.push_back({1'b0, w16, s, 16'h0000});
		busQ.push_back({1'b1, w16, d, w16 ? r : {8'h00, r[7:0]}});
	endtask
	task automatic drain;
		int i;
		for (i = 0; i < 300 && busQ.size() > 0; i++)
			@(posedge clk);
		if (busQ.size() > 0) begin
			fail("bus hang");
			end_of_test;
		end
		repeat (3) @(posedge clk);
	endtask
	task automatic pulse(input int n);
		@(posedge clk);
		periphIrq <= 64'h1 << n;
		@(posedge clk);
		periphIrq <= '0;
		repeat (3) @(posedge clk);
	endtask
	task automatic chkIrq(input logic e);
		@(negedge clk);
		tests_run++;
		if (irq !== e)
			fail("irq level");
		// Return on a rising edge so later drives land there
		@(posedge clk);
	endtask
	// ------
	// Monitors
	// ------
	always @(posedge clk) begin
		if (apbReq.psel && apbReq.penable && !apbReq.pwrite && pready) begin
			tests_run++;
			if (rdQ.size() == 0 || {pslverr, prdata} !== rdQ.pop_front())
				fail("read data");
		end
	end
	always @(posedge clk) begin
		if (busReqValid === 1'b1 && busAck === 1'b1) begin
			tests_run++;
			if (busQ.size() == 0 || {busReq.write, busReq.size16,
				busReq.addr, busReq.write ? busReq.wdata : 16'h0000}
				!== busQ.pop_front())
				fail("bus request");
		end
	end
	// ------
	// Scenarios
	// ------
	initial begin
		void'($urandom(30));
		src = 26'($urandom) & 26'h3ff7ffe | 26'h1;
		dst = 26'($urandom) & 26'h3ff7ffe;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		rd(`DCR_OFS_CHC, 32'h0);
		rd(8'h40, 32'h0, 1'b1);
		wr(`DCR_OFS_SRC_LO, {16'h0, src[15:0]});
		wr(`DCR_OFS_SRC_HI, {22'h0, src[25:16]});
		wr(`DCR_OFS_DST_LO, {16'h0, dst[15:0]});
		wr(`DCR_OFS_DST_HI, {22'h0, dst[25:16]});
		wr(`DCR_OFS_COUNT, 32'h2);
		wr(`DCR_OFS_ADC, 32'h4000);
		wr(`DCR_OFS_TRIG, 32'h5);
		wr(`DCR_OFS_MASK, 32'h3);
		unit(src & ~26'h1, dst, 1'b1);
		wr(`DCR_OFS_CHC, 32'h5);
		drain;
		rd(`DCR_OFS_CHC, 32'h1);
		unit((src & ~26'h1) + 2, dst + 2, 1'b1);
		pulse(5);
		drain;
		rd(`DCR_OFS_CHC, 32'h80);
		rd(`DCR_OFS_SRC_LO, {16'h0, src[15:0] & 16'hfffe} + 4);
		rd(`DCR_OFS_STAT, 32'h3);
		chkIrq(1'b1);
		wr(`DCR_OFS_CHC, 32'h80);
		rd(`DCR_OFS_CHC, 32'h80);
		wr(`DCR_OFS_STAT, 32'h3);
		rd(`DCR_OFS_STAT, 32'h0);
		chkIrq(1'b0);
		standby <= 1'b1;
		pulse(5);
		rd(`DCR_OFS_TRIG, 32'h5);
		standby <= 1'b0;
		pulse(5);
		rd(`DCR_OFS_TRIG, 32'h105);
		rd(`DCR_OFS_STAT, 32'h2);
		wr(`DCR_OFS_MASK, 32'h1);
		chkIrq(1'b0);
		wr(`DCR_OFS_CHC, 32'h2);
		rd(`DCR_OFS_TRIG, 32'h5);
		rd(`DCR_OFS_CHC, 32'h0);
		// Byte block from an odd address keeps that address
		wr(`DCR_OFS_COUNT, 32'h1);
		wr(`DCR_OFS_ADC, 32'h0);
		unit(src, dst + 4, 1'b0);
		wr(`DCR_OFS_SRC_LO, {16'h0, src[15:0]});
		wr(`DCR_OFS_CHC, 32'h5);
		drain;
		rd(`DCR_OFS_CHC, 32'h80);
		end_of_test;
	end
endmodule

bind dcr_channel dcr_channel_assertions u_dcr_channel_assertions (
	.clk(clk), .rst(rst), .apbReq(apbReq), .pslverr(pslverr),
	.prdata(prdata), .busReqValid(busReqValid), .busReq(busReq),
	.busAck(busAck), .busRdData(busRdData), .irq(irq));
